// *** hdl/scdma_defs.svh ***
// Register offsets, field positions and reset values for the serializer block
`ifndef SCDMA_DEFS_SVH
`define SCDMA_DEFS_SVH

`define SCDMA_NUM_SER        10
`define SCDMA_WORD_W         32
`define SCDMA_ADDR_W         12

// Byte offsets of single registers
`define SCDMA_OFS_GLOBAL     12'h000
`define SCDMA_OFS_PINFUNC    12'h004
`define SCDMA_OFS_XEVT       12'h008
`define SCDMA_OFS_STATUS     12'h00C

// Banks of per-serializer registers, one word each, index in bits 5:2
`define SCDMA_BANK_LSB       6
`define SCDMA_BANK_W         2
`define SCDMA_BANK_GLOBAL    2'h0
`define SCDMA_BANK_CTRL      2'h1
`define SCDMA_BANK_TRANSMIT_BUFFER      2'h2
`define SCDMA_BANK_RECEIVE_BUFFER      2'h3

// Serializer control fields
`define SCDMA_ROLE_LSB       0
`define SCDMA_DRIVE_LSB      2
`define SCDMA_TX_BUFFER_EMPTY_FLAG_BIT       4
`define SCDMA_RX_BUFFER_FULL_FLAG_BIT       5
`define SCDMA_ROLE_INACTIVE  2'h0
`define SCDMA_ROLE_TX        2'h1
`define SCDMA_ROLE_RX        2'h2
`define SCDMA_DRIVE_HIZ      2'h0
`define SCDMA_DRIVE_LOW      2'h2
`define SCDMA_DRIVE_HIGH     2'h3

// Other fields
`define SCDMA_TXCLR_BIT      0
`define SCDMA_DMADIS_BIT     0
`define SCDMA_UNDERRUN_LSB   16

// Reset values
`define SCDMA_RST_CTRL       4'h0
`define SCDMA_RST_DMADIS     1'h0
`define SCDMA_RST_PINFUNC    10'h000

`endif

// *** hdl/scdma_pkg.sv ***
// Types shared by the serializer control block
package scdma_pkg;
    `include "scdma_defs.svh"

    // Software controlled setting of one serializer
    typedef struct packed {
        logic [1:0] idle_pin_drive_mode;
        logic [1:0] serializer_role;
    } scdma_ser_ctrl_t;

    // Serial pin as two signals
    typedef struct packed {
        logic data_out;
        logic data_oe;
    } scdma_pin_t;
endpackage

// *** hdl/scdma_serializer.sv ***
// One serializer: buffers, shift register, ready flags and pin drive
`timescale 1ns/1ps
`include "scdma_defs.svh"
module scdma_serializer
    import scdma_pkg::*;
(
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire scdma_ser_ctrl_t ctrl,
    input  wire logic            gpio_sel,
    input  wire logic            tx_clear,
    input  wire logic            tx_clear_rise,
    input  wire logic            bit_tick,
    input  wire logic            slot_tick,
    input  wire logic            din,
    input  wire logic            buf_wr,
    input  wire logic [31:0]     buf_wdata,
    input  wire logic            receive_buffer_rd,
    output logic                 tx_buffer_empty_flag,
    output logic                 rx_buffer_full_flag,
    output logic [31:0]          receive_buffer,
    output scdma_pin_t           pin,
    output logic                 overrun,
    output logic                 underrun
);
    logic        is_tx;
    logic        is_rx;
    logic [31:0] transmit_buffer;
    logic [31:0] shreg;
    logic        tx_active;
    logic        rx_primed;

    assign is_tx = (ctrl.serializer_role == `SCDMA_ROLE_TX);
    assign is_rx = (ctrl.serializer_role == `SCDMA_ROLE_RX);

    // Transmit buffer holds the last word software wrote
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transmit_buffer <= 32'h0;
        end else if (buf_wr) begin
            transmit_buffer <= buf_wdata;
        end
    end

    // Buffer-empty flag; a write in the load cycle keeps it clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buffer_empty_flag <= 1'b0;
        end else if (!is_tx || !tx_clear) begin
            tx_buffer_empty_flag <= 1'b0;
        end else if (buf_wr) begin
            tx_buffer_empty_flag <= 1'b0;
        end else if (tx_clear_rise || slot_tick) begin
            tx_buffer_empty_flag <= 1'b1;
        end
    end

    // Shift register: load at slot start for transmit, shift in for receive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shreg     <= 32'h0;
            tx_active <= 1'b0;
        end else if (!is_tx || !tx_clear) begin
            tx_active <= 1'b0;
            if (is_rx && bit_tick) begin
                shreg <= {shreg[30:0], din};
            end
        end else if (slot_tick) begin
            shreg     <= transmit_buffer;
            tx_active <= !tx_buffer_empty_flag; // Empty buffer leaves the slot idle
        end else if (bit_tick) begin
            shreg <= {shreg[30:0], 1'b0};
        end
    end

    // Completed word moves to the receive buffer at each later slot start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            receive_buffer      <= 32'h0;
            rx_primed <= 1'b0;
        end else if (!is_rx) begin
            rx_primed <= 1'b0;
        end else if (slot_tick) begin
            rx_primed <= 1'b1;
            if (rx_primed) begin
                receive_buffer <= shreg;
            end
        end
    end

    // Buffer-full flag; new word wins over a read in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buffer_full_flag <= 1'b0;
        end else if (!is_rx) begin
            rx_buffer_full_flag <= 1'b0;
        end else if (slot_tick && rx_primed) begin
            rx_buffer_full_flag <= 1'b1;
        end else if (receive_buffer_rd) begin
            rx_buffer_full_flag <= 1'b0;
        end
    end

    // Missed service at slot start, one-cycle pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun  <= 1'b0;
            underrun <= 1'b0;
        end else begin
            overrun  <= is_rx && slot_tick && rx_primed && rx_buffer_full_flag && !receive_buffer_rd;
            underrun <= is_tx && slot_tick && tx_clear && tx_buffer_empty_flag && !buf_wr;
        end
    end

    // Pin drive; idle mode only counts when the pin belongs to the port
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin <= '0;
        end else if (gpio_sel) begin
            pin <= '0;
        end else if (is_tx && tx_active) begin
            pin <= '{data_out: shreg[31], data_oe: 1'b1};
        end else if (is_rx) begin
            pin <= '0;
        end else begin
            unique case (ctrl.idle_pin_drive_mode)
                `SCDMA_DRIVE_LOW:  pin <= '{data_out: 1'b0, data_oe: 1'b1};
                `SCDMA_DRIVE_HIGH: pin <= '{data_out: 1'b1, data_oe: 1'b1};
                default:           pin <= '0; // High impedance and reserved code
            endcase
        end
    end
endmodule

// *** hdl/scdma_sync.sv ***
// Two flip-flop synchroniser for levels arriving from outside the pclk domain
`timescale 1ns/1ps
module scdma_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    // First stage is read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// *** hdl/scdma_top.sv ***
// Serializer control and transmit DMA gating with an APB register slave
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "scdma_defs.svh"
// Notes on behaviour
// - DMA control bit 0 set to 1 suppresses the transmit DMA request.
// - Unused upper bits of DMA and serializer control read zero, ignore writes.
// - Ten serializers, each with its own control register.
// - Role field codes: 0 inactive, 1 transmit, 2 receive, 3 reserved.
// - Receive flag reads 0 unless receiving; sets when a word reaches the buffer.
// - Unread receive word at next slot start counts as receive overrun.
// - Transmit flag reads 0 unless transmitting; sets when transmit clear rises.
// - Transmit flag holds until clear drops, buffer written, or role leaves transmit.
// - Unwritten transmit buffer at next slot start counts as transmit underrun.
// - Idle drive field: 0 high impedance, 2 low, 3 high, 1 reserved.
// - Idle drive applies only when the pin is assigned to the port.
module scdma_top
    import scdma_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   serial_clk,
    input  wire logic                   frame_sync,
    input  wire logic [9:0]             ser_data_in,
    output logic      [9:0]             ser_data_out,
    output logic      [9:0]             ser_data_oe,
    output logic                        tx_dma_req
);
    localparam int NSER = `SCDMA_NUM_SER;

    logic [11:0]           sync_q;
    logic                  sclk_s;
    logic                  fsync_s;
    logic [NSER-1:0]       din_s;
    logic                  sclk_prev;
    logic                  bit_tick;
    logic                  slot_tick;
    logic                  tx_serializer_clear;
    logic                  tx_clear_prev;
    logic                  tx_clear_rise;
    logic [NSER-1:0]       pin_function_select;
    logic                  tx_dma_request_disable;
    scdma_ser_ctrl_t       ser_ctrl [NSER];
    logic [NSER-1:0]       tx_buffer_empty_flag;
    logic [NSER-1:0]       rx_buffer_full_flag;
    logic [31:0]           receive_buffer [NSER];
    logic [NSER-1:0]       overrun;
    logic [NSER-1:0]       underrun;
    logic [NSER-1:0]       overrun_sticky;
    logic [NSER-1:0]       underrun_sticky;
    logic [NSER-1:0]       tx_role;
    scdma_pin_t            pin [NSER];
    logic [1:0]            bank;
    logic [3:0]            idx;
    logic                  idx_ok;
    logic                  mapped;
    logic                  access;
    logic                  wr_en;
    logic                  rd_en;
    logic [31:0]           next_rdata;

    // Link clock, frame sync and data pins come from outside pclk
    scdma_sync #(
        .WIDTH (12)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({serial_clk, frame_sync, ser_data_in}),
        .sync_out (sync_q)
    );

    assign sclk_s  = sync_q[11];
    assign fsync_s = sync_q[10];
    assign din_s   = sync_q[9:0];

    // Edge finder on the synchronised link clock; sampling needs pclk > 2x link clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev     <= 1'b0;
            tx_clear_prev <= 1'b0;
        end else begin
            sclk_prev     <= sclk_s;
            tx_clear_prev <= tx_serializer_clear;
        end
    end

    assign bit_tick      = sclk_s && !sclk_prev;
    assign slot_tick     = bit_tick && fsync_s;
    assign tx_clear_rise = tx_serializer_clear && !tx_clear_prev;

    // APB decode; the request is held, so the access phase sees it unchanged
    assign bank   = paddr[`SCDMA_BANK_LSB +: `SCDMA_BANK_W];
    assign idx    = paddr[5:2];
    assign idx_ok = (idx < 4'(NSER));
    assign access = psel && penable && pready;
    assign wr_en  = access && pwrite && mapped;
    assign rd_en  = access && !pwrite && mapped;

    // Which addresses answer; unimplemented serializers get an error
    always_comb begin
        mapped = 1'b0;
        if (paddr[1:0] == 2'h0 && paddr[11:8] == 4'h0) begin
            if (bank == `SCDMA_BANK_GLOBAL) begin
                mapped = (paddr == `SCDMA_OFS_GLOBAL) ||
                         (paddr == `SCDMA_OFS_PINFUNC) ||
                         (paddr == `SCDMA_OFS_XEVT) ||
                         (paddr == `SCDMA_OFS_STATUS);
            end else begin
                mapped = idx_ok;
            end
        end
    end

    // Ready in the first access cycle, no wait states; error on unmapped addresses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= mapped && !pwrite ? next_rdata : 32'h0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
    end

    // Read mux; reserved bits are zero
    always_comb begin
        next_rdata = 32'h0;
        unique case (bank)
            `SCDMA_BANK_GLOBAL: begin
                if (paddr == `SCDMA_OFS_GLOBAL) begin
                    next_rdata[`SCDMA_TXCLR_BIT] = tx_serializer_clear;
                end else if (paddr == `SCDMA_OFS_PINFUNC) begin
                    next_rdata[NSER-1:0] = pin_function_select;
                end else if (paddr == `SCDMA_OFS_XEVT) begin
                    next_rdata[`SCDMA_DMADIS_BIT] = tx_dma_request_disable;
                end else if (paddr == `SCDMA_OFS_STATUS) begin
                    next_rdata[NSER-1:0] = overrun_sticky;
                    next_rdata[`SCDMA_UNDERRUN_LSB +: NSER] = underrun_sticky;
                end
            end
            `SCDMA_BANK_CTRL: begin
                if (idx_ok) begin
                    next_rdata[3:0] = ser_ctrl[idx];
                    next_rdata[`SCDMA_TX_BUFFER_EMPTY_FLAG_BIT] = tx_buffer_empty_flag[idx];
                    next_rdata[`SCDMA_RX_BUFFER_FULL_FLAG_BIT] = rx_buffer_full_flag[idx];
                end
            end
            `SCDMA_BANK_TRANSMIT_BUFFER: next_rdata = 32'h0;
            `SCDMA_BANK_RECEIVE_BUFFER: begin
                if (idx_ok) begin
                    next_rdata = receive_buffer[idx];
                end
            end
        endcase
    end

    // Global transmit clear, pin assignment and DMA gate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_serializer_clear    <= 1'b0;
            pin_function_select    <= `SCDMA_RST_PINFUNC;
            tx_dma_request_disable <= `SCDMA_RST_DMADIS;
        end else if (wr_en && bank == `SCDMA_BANK_GLOBAL) begin
            if (paddr == `SCDMA_OFS_GLOBAL) begin
                tx_serializer_clear <= pwdata[`SCDMA_TXCLR_BIT];
            end
            if (paddr == `SCDMA_OFS_PINFUNC) begin
                pin_function_select <= pwdata[NSER-1:0];
            end
            if (paddr == `SCDMA_OFS_XEVT) begin
                tx_dma_request_disable <= pwdata[`SCDMA_DMADIS_BIT];
            end
        end
    end

    // Sticky error flags, write one to clear; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overrun_sticky  <= '0;
            underrun_sticky <= '0;
        end else if (wr_en && bank == `SCDMA_BANK_GLOBAL &&
                     paddr == `SCDMA_OFS_STATUS) begin
            overrun_sticky  <= (overrun_sticky & ~pwdata[NSER-1:0]) | overrun;
            underrun_sticky <= (underrun_sticky & ~pwdata[`SCDMA_UNDERRUN_LSB +: NSER])
                               | underrun;
        end else begin
            overrun_sticky  <= overrun_sticky | overrun;
            underrun_sticky <= underrun_sticky | underrun;
        end
    end

    // One control register and one serializer per channel
    for (genvar g = 0; g < NSER; g++) begin : g_ser
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ser_ctrl[g] <= `SCDMA_RST_CTRL;
            end else if (wr_en && bank == `SCDMA_BANK_CTRL && idx == 4'(g)) begin
                ser_ctrl[g] <= pwdata[3:0];
            end
        end

        assign tx_role[g] = (ser_ctrl[g].serializer_role == `SCDMA_ROLE_TX);

        scdma_serializer u_ser (
            .pclk          (pclk),
            .presetn       (presetn),
            .ctrl          (ser_ctrl[g]),
            .gpio_sel      (pin_function_select[g]),
            .tx_clear      (tx_serializer_clear),
            .tx_clear_rise (tx_clear_rise),
            .bit_tick      (bit_tick),
            .slot_tick     (slot_tick),
            .din           (din_s[g]),
            .buf_wr        (wr_en && bank == `SCDMA_BANK_TRANSMIT_BUFFER && idx == 4'(g)),
            .buf_wdata     (pwdata),
            .receive_buffer_rd       (rd_en && bank == `SCDMA_BANK_RECEIVE_BUFFER && idx == 4'(g)),
            .tx_buffer_empty_flag          (tx_buffer_empty_flag[g]),
            .rx_buffer_full_flag          (rx_buffer_full_flag[g]),
            .receive_buffer          (receive_buffer[g]),
            .pin           (pin[g]),
            .overrun       (overrun[g]),
            .underrun      (underrun[g])
        );

        assign ser_data_out[g] = pin[g].data_out;
        assign ser_data_oe[g]  = pin[g].data_oe;
    end

    // Request level follows the gate and any empty transmitter, one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_dma_req <= 1'b0;
        end else begin
            tx_dma_req <= !tx_dma_request_disable && |(tx_buffer_empty_flag & tx_role);
        end
    end
endmodule

// *** test/scdma_checker.sv ***
// Port-level assertions for the serializer control block
`timescale 1ns/1ps
module scdma_checker (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [9:0]  ser_data_oe,
    input  wire logic        tx_dma_req
);
    logic       dis;
    logic [9:0] pf;
    logic [9:0] txm;
    logic       txany;
    logic       wr_done;
    logic       rd_done;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign wr_done = psel && penable && pready && pwrite;
    assign rd_done = psel && penable && pready && !pwrite && !pslverr;
    assign txany = |txm;
    // Shadow copies of what the host wrote; roles only for the ten real indices
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dis <= 1'b0;
            pf <= 10'h000;
            txm <= 10'h000;
        end else if (wr_done) begin
            if (paddr == 12'h008) dis <= pwdata[0];
            if (paddr == 12'h004) pf <= pwdata[9:0];
            if (paddr[11:6] == 6'h01 && paddr[5:2] < 4'hA) txm[paddr[5:2]] <= pwdata[1:0] == 2'h1;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        psel && penable && pready;
    endsequence
    a_answer_next: assert property (s_setup |=> s_answer)
        else $error("no answer in the first access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_ready_idle: assert property (!psel |=> !pready)
        else $error("ready without a request");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside the answer cycle");
    a_err_misalign: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_ctrl_upper: assert property (rd_done && paddr[11:6] == 6'h01 |-> prdata[31:6] == 26'h0)
        else $error("control word upper bits not zero");
    a_gate_upper: assert property (rd_done && paddr == 12'h008 |-> prdata[31:1] == 31'h0)
        else $error("gate register upper bits not zero");
    a_gate_blocks: assert property (dis && $past(dis) && $past(dis, 2) |-> !tx_dma_req)
        else $error("request while gate disabled");
    a_req_needs_tx: assert property (tx_dma_req |-> txany || $past(txany) || $past(txany, 2))
        else $error("request with no transmitter");
    a_pinfunc_off: assert property ((ser_data_oe & pf & $past(pf) & $past(pf, 2)) == 10'h000)
        else $error("pin driven while not a port pin");
endmodule

// *** test/scdma_codec_model.sv ***
// Converter model: bit clock and frame sync within frames, one word per slot
`timescale 1ns/1ps
module scdma_codec_model (
    input  wire logic        run,
    input  wire logic [31:0] word,
    output logic             serial_clk,
    output logic             frame_sync,
    output logic [9:0]       ser_data_in
);
    // Clock stands low between frames; offset keeps edges away from pclk edges
    initial begin
        serial_clk = 1'b0;
        frame_sync = 1'b0;
        ser_data_in = 10'h155;
        forever begin
            wait (run);
            #13;
            for (int b = 31; b >= 0; b--) begin
                frame_sync = (b == 31);
                ser_data_in = {10{word[b]}};
                #200 serial_clk = 1'b1;
                #200 serial_clk = 1'b0;
            end
            frame_sync = 1'b0;
            ser_data_in = ~ser_data_in;
        end
    end
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the serializer control block
`timescale 1ns/1ps
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        serial_clk, frame_sync, tx_dma_req, run;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  ser_data_in, ser_data_out, ser_data_oe;
    logic [31:0] w = 32'hA5C3_0F96;
    int          n_fail, n_compared;

    scdma_top scdma_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_clk(serial_clk), .frame_sync(frame_sync),
        .ser_data_in(ser_data_in), .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe),
        .tx_dma_req(tx_dma_req));
    scdma_codec_model scdma_codec_model_i (.run(run), .word(w), .serial_clk(serial_clk),
        .frame_sync(frame_sync), .ser_data_in(ser_data_in));

    always #25 pclk = ~pclk;

    task automatic give_verdict;
        $display("compared %0d, wrong %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One transfer; an idle cycle follows so strobes never change twice in a step
    task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic erv);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // No assumed latency; only the watchdog ends a hung wait
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask

    // Request is registered, so give it a few cycles to follow a write
    task automatic chk_req(input logic v);
        repeat (3) @(posedge pclk);
        check({31'h0, tx_dma_req}, {31'h0, v});
    endtask

    task automatic wait_slot;
        do @(posedge serial_clk); while (frame_sync !== 1'b1);
    endtask

    initial begin
        repeat (6000) @(posedge pclk);
        n_fail++;
        give_verdict;
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        run = 1'b0;
        n_fail = 0;
        n_compared = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values, reserved bits and roles; only indices 0..9 are touched
        rd_chk(12'h008, 32'h0);
        wr(12'h008, 32'hFFFF_FFFE);
        rd_chk(12'h008, 32'h0);
        wr(12'h008, 32'hFFFF_FFFF);
        rd_chk(12'h008, 32'h1);
        wr(12'h008, 32'h0);
        for (int n = 0; n < 10; n++) begin
            rd_chk(12'h040 + 12'(4 * n), 32'h0);
            wr(12'h040 + 12'(4 * n), 32'hFFFF_FFC6);
            rd_chk(12'h040 + 12'(4 * n), 32'h06);
            wr(12'h040 + 12'(4 * n), 32'h0);
        end
        for (int c = 0; c < 4; c++) begin
            wr(12'h040, 32'(c));
            rd_chk(12'h040, 32'(c));
        end
        wr(12'h040, 32'h0);
        apb(1'b1, 12'h00B, 32'h1, rd, er);
        check({31'h0, er}, 32'h1);
        rd_chk(12'h008, 32'h0);
        $display("registers done");
        // Idle drive codes on an inactive serializer, then pin given away
        for (int c = 0; c < 4; c++) begin
            wr(12'h044, 32'(c << 2));
            repeat (3) @(posedge pclk);
            check({31'h0, ser_data_oe[1]}, {31'h0, c >= 2});
            check({31'h0, ser_data_oe[1] & ser_data_out[1]}, {31'h0, c == 3});
        end
        wr(12'h004, 32'h002);
        repeat (3) @(posedge pclk);
        check({31'h0, ser_data_oe[1]}, 32'h0);
        wr(12'h004, 32'h0);
        wr(12'h044, 32'h0);
        $display("pin drive done");
        // Transmit flag life cycle and request gating
        wr(12'h040, 32'h1);
        chk_req(1'b0);
        wr(12'h000, 32'h1);
        rd_chk(12'h040, 32'h11);
        chk_req(1'b1);
        wr(12'h008, 32'h1);
        chk_req(1'b0);
        wr(12'h008, 32'h0);
        chk_req(1'b1);
        wr(12'h080, 32'h1234_5678);
        rd_chk(12'h040, 32'h01);
        chk_req(1'b0);
        wr(12'h000, 32'h0);
        wr(12'h000, 32'h1);
        rd_chk(12'h040, 32'h11);
        wr(12'h000, 32'h0);
        rd_chk(12'h040, 32'h01);
        wr(12'h000, 32'h1);
        rd_chk(12'h040, 32'h11);
        wr(12'h040, 32'h2);
        rd_chk(12'h040, 32'h02);
        chk_req(1'b0);
        $display("transmit flag done");
        // Link traffic: word out MSB first, then underrun and overrun
        wr(12'h000, 32'h0);
        wr(12'h040, 32'h1);
        wr(12'h044, 32'h2);
        wr(12'h000, 32'h1);
        wr(12'h080, w);
        run <= 1'b1;
        wait_slot;
        for (int b = 31; b >= 0; b--) begin
            if (b != 31) @(posedge serial_clk);
            repeat (6) @(posedge pclk);
            check({30'h0, ser_data_oe[0], ser_data_out[0]}, {30'h0, 1'b1, w[b]});
        end
        wait_slot;
        wait_slot;
        run <= 1'b0;
        repeat (8) @(posedge pclk);
        rd_chk(12'h00C, 32'h0001_0002);
        rd_chk(12'h044, 32'h22);
        rd_chk(12'h0C4, w);
        rd_chk(12'h044, 32'h02);
        wr(12'h00C, 32'hFFFF_FFFF);
        rd_chk(12'h00C, 32'h0);
        $display("link done");
        give_verdict;
    end
endmodule

bind scdma_top scdma_checker scdma_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ser_data_oe(ser_data_oe), .tx_dma_req(tx_dma_req));
